// file: rtl/dual_adc_setup_trim.sv
// setup register, analog clock prescaler and offset trim for two channels
`timescale 1ns/1ps
`default_nettype none

`include "dual_adc_params.svh"

module dual_adc_setup_trim
  import dual_adc_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // register access port
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [23:0] reg_wdata_in,
  output var  logic [23:0] reg_rdata_out,
  output var  logic        reg_rvalid_out,
  // trim enable from the status/communication side
  input  wire logic        offset_trim_enable_in,
  // raw converter codes
  input  wire logic [23:0] ch0_code_in,
  input  wire logic        ch0_valid_in,
  input  wire logic [23:0] ch1_code_in,
  input  wire logic        ch1_valid_in,
  // corrected codes
  output var  logic [23:0] ch0_code_out,
  output var  logic        ch0_valid_out,
  output var  logic [23:0] ch1_code_out,
  output var  logic        ch1_valid_out,
  // analog control
  output var  logic        analog_clock_out,
  output var  logic [2:0]  oversample_ratio_sel_out,
  output var  logic [12:0] oversample_ratio_out,
  output var  logic [1:0]  dither_strength_sel_out,
  output var  logic        autozero_speed_out,
  output var  logic [1:0]  ch_reset_out,
  output var  logic [1:0]  ch_shutdown_out,
  output var  logic        internal_ref_disable_out,
  output var  logic        external_clock_sel_out,
  output var  logic        crystal_osc_enable_out
);

  // ------------------------------------------------------------------
  // block overview
  // ------------------------------------------------------------------
  // the host sees three registers on a strobe port: the 16-bit setup
  // word and one 24-bit trim word per channel. setup fields fan straight
  // out to the analog side, so a field change shows one edge after the write.
  // trim words feed the correction lanes, which sit in the sample path
  // and always add one register stage whether trim is on or off, so the
  // host never sees the data timing move when it flips the enable.
  // unmapped addresses read as zero and ignore writes, which keeps
  // a host that scans the map from seeing stale bus data.
  // limitation: nothing here checks that the host spaces its strobes.

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------

  // last count of the prescaler for a field code
  // the counter runs 0..last, so last is the divisor minus one;
  // code 3 reaches 7, which is why the counter is three bits wide
  function automatic logic [2:0] presc_last(input logic [1:0] code);
    case (code)
      2'h0:    presc_last = 3'h0;
      2'h1:    presc_last = 3'h1;
      2'h2:    presc_last = 3'h3;
      default: presc_last = 3'h7;
    endcase
  endfunction : presc_last

  // ratio for an oversampling code: base shifted by code
  // a shift keeps the ratio table out of logic: 32 << 7 is 4096,
  // which needs the full 13-bit width of the ratio type
  function automatic osr_ratio_t osr_ratio(input logic [2:0] code);
    osr_ratio = osr_ratio_t'(`OSR_BASE << code);
  endfunction : osr_ratio

  // address match for a register
  // kept as a function so every decoder compares the same way
  function automatic logic hit(input reg_addr_t a, input reg_addr_t r);
    hit = (a == r);
  endfunction : hit

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------

  setup_word_t setup_q;
  setup_word_t setup_d;
  code_t       trim_q [CHANNELS];
  code_t       trim_d [CHANNELS];
  reg_addr_t   trim_addr [CHANNELS];

  assign trim_addr[0] = `TRIM0_ADDR;
  assign trim_addr[1] = `TRIM1_ADDR;

  // writes: setup keeps unimplemented bits at zero
  // the mask is applied on the way in, so the stored word itself
  // never holds a one in the unused positions
  always_comb begin
    setup_d = setup_q;
    if (reg_wr_in && hit(reg_addr_in, `SETUP_ADDR)) begin
      setup_d = reg_wdata_in[15:0] & `SETUP_WR_MASK;
    end
  end

  // trim values only change by write; the enable never clears them
  // a write and a sample in one cycle: the lane still sees the old
  // trim that cycle and the new one from the next sample on
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_trim_wr
      always_comb begin
        trim_d[g] = trim_q[g];
        if (reg_wr_in && hit(reg_addr_in, trim_addr[g])) begin
          trim_d[g] = reg_wdata_in;
        end
      end

      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          trim_q[g] <= `TRIM_RESET;
        end else begin
          trim_q[g] <= trim_d[g];
        end
      end
    end
  endgenerate

  // setup word flop; the reset value carries every field default
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      setup_q <= `SETUP_RESET;
    end else begin
      setup_q <= setup_d;
    end
  end

  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------

  code_t rdata_q;
  code_t rdata_d;
  logic  rvalid_q;
  logic  rvalid_d;

  // one cycle read latency; unmapped addresses return zero
  // read data holds between reads so a slow host can pick it up late;
  // a read and a write to one address in one cycle return the old word
  always_comb begin
    rvalid_d = reg_rd_in;
    rdata_d  = rdata_q;
    if (reg_rd_in) begin
      if (hit(reg_addr_in, `SETUP_ADDR)) begin
        rdata_d = {8'h00, setup_q & `SETUP_WR_MASK};
      end else if (hit(reg_addr_in, `TRIM0_ADDR)) begin
        rdata_d = trim_q[0];
      end else if (hit(reg_addr_in, `TRIM1_ADDR)) begin
        rdata_d = trim_q[1];
      end else begin
        rdata_d = 24'h000000;
      end
    end
  end

  // registered answer; rvalid is a one-cycle pulse per read strobe
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q  <= 24'h000000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata_out  = rdata_q;
  assign reg_rvalid_out = rvalid_q;

  // ------------------------------------------------------------------
  // analog clock prescaler
  // ------------------------------------------------------------------

  logic [2:0] presc_cnt_q;
  logic [2:0] presc_cnt_d;
  logic       aclk_en_q;
  logic       aclk_en_d;
  logic [2:0] presc_lim;

  // the counter is free running: the analog side only needs a steady
  // enable rate, not a fixed phase against register writes, and a
  // divisor change settles within one new period
  // a one-cycle enable per divided period; >= guards a shrinking divisor
  always_comb begin
    presc_lim = presc_last(setup_q[`PRE_MSB:`PRE_LSB]);
    if (presc_cnt_q >= presc_lim) begin
      presc_cnt_d = 3'h0;
      aclk_en_d   = 1'b1;
    end else begin
      presc_cnt_d = presc_cnt_q + 3'h1;
      aclk_en_d   = 1'b0;
    end
  end

  // counter and enable flops
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_cnt_q <= 3'h0;
      aclk_en_q   <= 1'b0;
    end else begin
      presc_cnt_q <= presc_cnt_d;
      aclk_en_q   <= aclk_en_d;
    end
  end

  assign analog_clock_out = aclk_en_q;

  // ------------------------------------------------------------------
  // analog control outputs
  // ------------------------------------------------------------------

  osr_ratio_t ratio_q;
  osr_ratio_t ratio_d;
  logic       xtal_en_q;
  logic       xtal_en_d;

  // derived values kept in flops so every output leaves a register
  always_comb begin
    ratio_d   = osr_ratio(setup_q[`OSR_MSB:`OSR_LSB]);
    xtal_en_d = ~setup_q[`EXT_CLK_BIT];
  end

  // ratio and crystal enable lag the setup word by one edge
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ratio_q   <= `OSR_RESET_RATIO;
      xtal_en_q <= 1'b0;
    end else begin
      ratio_q   <= ratio_d;
      xtal_en_q <= xtal_en_d;
    end
  end

  // field bits drive the analog side directly
  // the setup flops are the output flops for the field bits; no extra stage, so those
  // outputs follow a write one edge after it lands; ratio and crystal enable follow one edge later
  assign oversample_ratio_sel_out = setup_q[`OSR_MSB:`OSR_LSB];
  assign oversample_ratio_out     = ratio_q;
  assign dither_strength_sel_out  = setup_q[`DITH_MSB:`DITH_LSB];
  assign autozero_speed_out       = setup_q[`AZ_BIT];
  assign ch_reset_out             = setup_q[`RST_MSB:`RST_LSB];
  assign ch_shutdown_out          = setup_q[`SHDN_MSB:`SHDN_LSB];
  assign internal_ref_disable_out = setup_q[`REFDIS_BIT];
  assign external_clock_sel_out   = setup_q[`EXT_CLK_BIT];
  assign crystal_osc_enable_out   = xtal_en_q;

  // ------------------------------------------------------------------
  // offset trim lanes
  // ------------------------------------------------------------------

  code_t code_in  [CHANNELS];
  logic  valid_in [CHANNELS];

  assign code_in[0]  = ch0_code_in;
  assign code_in[1]  = ch1_code_in;
  assign valid_in[0] = ch0_valid_in;
  assign valid_in[1] = ch1_valid_in;

  trim_lane_if lane_bus [CHANNELS] ();

  // one shared enable serves both channels
  // each lane saturates on its own; one lane clamping never touches
  // the other channel's sample
  // channel reset and shutdown do not gate the lanes: codes from a
  // held channel pass through as presented
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_lane
      assign lane_bus[g].code   = code_in[g];
      assign lane_bus[g].valid  = valid_in[g];
      assign lane_bus[g].offset = trim_q[g];
      assign lane_bus[g].enable = offset_trim_enable_in;

      offset_trim_lane u_lane (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .lane     (lane_bus[g])
      );
    end
  endgenerate

  // lane outputs are the lane flops, passed through unchanged
  assign ch0_code_out  = lane_bus[0].result;
  assign ch0_valid_out = lane_bus[0].result_valid;
  assign ch1_code_out  = lane_bus[1].result;
  assign ch1_valid_out = lane_bus[1].result_valid;

endmodule : dual_adc_setup_trim

`default_nettype wire

// file: rtl/offset_trim_lane.sv
// one channel of offset correction: add signed trim, saturate, register
`timescale 1ns/1ps
`default_nettype none

`include "dual_adc_params.svh"

module offset_trim_lane
  import dual_adc_pkg::*;
(
  input  wire logic   mclk_in,
  input  wire logic   rst_n_in,
  trim_lane_if.lane   lane
);

  code_t      result_q;
  code_t      result_d;
  logic       valid_q;
  logic       valid_d;
  logic [24:0] sum;

  // signed add with clamp; both modes share one register stage
  always_comb begin
    sum      = {lane.code[23], lane.code} + {lane.offset[23], lane.offset};
    result_d = result_q;
    valid_d  = lane.valid;
    if (lane.valid) begin
      if (!lane.enable) begin
        result_d = lane.code;
      end else if (sum[24] != sum[23]) begin
        // wrap would flip sign of a full-scale code, so clamp instead
        result_d = sum[24] ? 24'h800000 : 24'h7fffff;
      end else begin
        result_d = sum[23:0];
      end
    end
  end

  // same latency with trim on or off
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_q <= 24'h000000;
      valid_q  <= 1'b0;
    end else begin
      result_q <= result_d;
      valid_q  <= valid_d;
    end
  end

  assign lane.result       = result_q;
  assign lane.result_valid = valid_q;

endmodule : offset_trim_lane

`default_nettype wire

// file: shared/dual_adc_params.svh
// constants for the two-channel converter setup and offset trim block
//
// Summary of operation
// - prescaler field divides master clock by 1, 2, 4 or 8; default 1.
// - oversampling field picks 32 to 4096 for both channels; default 256.
// - dither field 11 max default, 10 medium, 01 minimum, 00 off.
// - auto-zero speed bit 1 runs fast, 0 runs slow by default.
// - reset field holds channel 0, channel 1, both or neither; default neither.
// - shutdown field stops channel 0, channel 1, both or neither; default neither.
// - unimplemented setup bits 3 and 0 always read as zero.
// - reference bit 1 disables internal reference; 0 keeps it on by default.
// - clock select 1 uses external clock, 0 enables crystal; default 1.
// - two 24-bit read/write trim registers at 0x0e and 0x14, reset zero.
// - when enabled, signed trim value is added to that channel's code.
// - when disabled the trim registers are ignored but keep their values.
// - one enable bit covers both channels, default off, no extra delay.
`ifndef DUAL_ADC_PARAMS_SVH
`define DUAL_ADC_PARAMS_SVH

// register addresses
`define SETUP_ADDR       8'h0c
`define TRIM0_ADDR       8'h0e
`define TRIM1_ADDR       8'h14

// setup register reset value and writable mask
`define SETUP_RESET      16'h1e02
`define SETUP_WR_MASK    16'hfff6
`define TRIM_RESET       24'h000000

// setup register field positions
`define PRE_MSB          15
`define PRE_LSB          14
`define OSR_MSB          13
`define OSR_LSB          11
`define DITH_MSB         10
`define DITH_LSB         9
`define AZ_BIT           8
`define RST_MSB          7
`define RST_LSB          6
`define SHDN_MSB         5
`define SHDN_LSB         4
`define REFDIS_BIT       2
`define EXT_CLK_BIT      1

// oversampling ratio at code zero; each code step doubles it
`define OSR_BASE         13'h0020
// ratio flop value while reset holds, matching the default code 011
`define OSR_RESET_RATIO  13'h0100

`endif

// file: shared/dual_adc_pkg.sv
// types shared by the setup and offset trim block
package dual_adc_pkg;

  typedef logic [23:0] code_t;
  typedef logic [15:0] setup_word_t;
  typedef logic [7:0]  reg_addr_t;
  typedef logic [12:0] osr_ratio_t;

endpackage : dual_adc_pkg

// file: shared/trim_lane_if.sv
// carrier between the top and one offset trim lane
`timescale 1ns/1ps
`default_nettype none

interface trim_lane_if;
  import dual_adc_pkg::*;

  code_t code;
  logic  valid;
  code_t offset;
  logic  enable;
  code_t result;
  logic  result_valid;

  modport lane (input code, valid, offset, enable, output result, result_valid);
  modport top  (output code, valid, offset, enable, input result, result_valid);
endinterface : trim_lane_if

`default_nettype wire

// file: testbench/dual_adc_checker.sv
// port assertions for the setup and offset trim block
`timescale 1ns/1ps
`default_nettype none

module dual_adc_checker (
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [23:0] reg_wdata_in,
  input wire logic [23:0] reg_rdata_out,
  input wire logic        reg_rvalid_out,
  input wire logic        offset_trim_enable_in,
  input wire logic [23:0] ch0_code_in,
  input wire logic        ch0_valid_in,
  input wire logic        ch1_valid_in,
  input wire logic [23:0] ch0_code_out,
  input wire logic        ch0_valid_out,
  input wire logic        ch1_valid_out,
  input wire logic        analog_clock_out,
  input wire logic [2:0]  oversample_ratio_sel_out,
  input wire logic [12:0] oversample_ratio_out,
  input wire logic        external_clock_sel_out,
  input wire logic        crystal_osc_enable_out
);
  // prescaler field shadow; the field has no port of its own
  logic [1:0] pre_q;
  logic [1:0] pre_d;
  always_comb begin
    pre_d = pre_q;
    if (reg_wr_in && reg_addr_in == 8'h0c) pre_d = reg_wdata_in[15:14];
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) pre_q <= 2'h0;
    else pre_q <= pre_d;
  end

  // ----------------
  // assertions
  // ----------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_rvalid;
    reg_rd_in |=> reg_rvalid_out ##1 (reg_rvalid_out == $past(reg_rd_in));
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  property p_valid;
    (ch0_valid_out == $past(ch0_valid_in)) && (ch1_valid_out == $past(ch1_valid_in));
  endproperty
  a_valid: assert property (p_valid) else $error("sample latency off");
  property p_bypass;
    ch0_valid_in && !offset_trim_enable_in |=> ch0_code_out == $past(ch0_code_in);
  endproperty
  a_bypass: assert property (p_bypass) else $error("trim applied while off");
  property p_osr;
    $stable(oversample_ratio_sel_out) ##1 $stable(oversample_ratio_sel_out)
      |-> oversample_ratio_out == (13'h0020 << oversample_ratio_sel_out);
  endproperty
  a_osr: assert property (p_osr) else $error("ratio does not match code");
  property p_xtal;
    crystal_osc_enable_out != $past(external_clock_sel_out);
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal enable wrong");
  property p_unimpl;
    reg_rd_in && reg_addr_in == 8'h0c |=>
      reg_rdata_out[23:16] == 8'h00 && !reg_rdata_out[3] && !reg_rdata_out[0];
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused setup bit set");
  property p_div1;
    $past(rst_n_in) && pre_q == 2'h0 && $past(pre_q) == 2'h0 && $past(pre_q, 2) == 2'h0
      |-> analog_clock_out;
  endproperty
  a_div1: assert property (p_div1) else $error("undivided clock gap");
  property p_gap;
    $past(rst_n_in) && pre_q != 2'h0 && $past(pre_q) == pre_q && $past(pre_q, 2) == pre_q
      && analog_clock_out |-> !$past(analog_clock_out);
  endproperty
  a_gap: assert property (p_gap) else $error("divided clock pulses adjacent");
endmodule : dual_adc_checker

`default_nettype wire

// file: testbench/dual_adc_setup_trim_test.sv
// self-checking bench for the setup and offset trim block
`timescale 1ns/1ps
`default_nettype none

module dual_adc_setup_trim_test;
  logic        mclk_in, rst_n_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
  logic        offset_trim_enable_in, ch0_valid_in, ch1_valid_in, ch0_valid_out;
  logic        ch1_valid_out, analog_clock_out, autozero_speed_out;
  logic        internal_ref_disable_out, external_clock_sel_out, crystal_osc_enable_out;
  logic [7:0]  reg_addr_in;
  logic [23:0] reg_wdata_in, reg_rdata_out, ch0_code_in, ch1_code_in;
  logic [23:0] ch0_code_out, ch1_code_out, got;
  logic [2:0]  oversample_ratio_sel_out, k;
  logic [12:0] oversample_ratio_out, sets, exp_sets;
  logic [1:0]  dither_strength_sel_out, ch_reset_out, ch_shutdown_out;
  logic [15:0] v;
  int          error_cnt, comparisons, pulses;

  // setting outputs packed for one comparison
  assign sets = {oversample_ratio_sel_out, dither_strength_sel_out, autozero_speed_out,
                 ch_reset_out, ch_shutdown_out, internal_ref_disable_out,
                 external_clock_sel_out, crystal_osc_enable_out};

  dual_adc_setup_trim dut (.*);
  host_model host (.mclk_in, .rvalid_in(reg_rvalid_out), .rdata_in(reg_rdata_out),
    .wr_out(reg_wr_in), .rd_out(reg_rd_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));

  // ----------------
  // tasks
  // ----------------
  task automatic cmp(input logic [23:0] g, input logic [23:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // both channels sampled together, checked one cycle later
  task automatic sample(input logic [23:0] a, input logic [23:0] b,
                        input logic [23:0] ea, input logic [23:0] eb);
    @(negedge mclk_in);
    ch0_code_in  = a;
    ch1_code_in  = b;
    ch0_valid_in = 1'b1;
    ch1_valid_in = 1'b1;
    @(negedge mclk_in);
    ch0_valid_in = 1'b0;
    ch1_valid_in = 1'b0;
    cmp({22'h0, ch0_valid_out, ch1_valid_out}, 24'h000003);
    cmp(ch0_code_out, ea);
    cmp(ch1_code_out, eb);
  endtask : sample
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // whole run is a few hundred cycles; ten times that means a hang
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end

  initial begin
    rst_n_in              = 1'b0;
    offset_trim_enable_in = 1'b0;
    ch0_valid_in          = 1'b0;
    ch1_valid_in          = 1'b0;
    ch0_code_in           = 24'h000000;
    ch1_code_in           = 24'h000000;
    error_cnt             = 0;
    comparisons           = 0;
    repeat (6) @(negedge mclk_in);
    rst_n_in = 1'b1;
    host.rd(8'h0c, got);
    cmp(got, 24'h001e02);
    cmp({11'h0, sets}, 24'h000f02);
    cmp({11'h0, oversample_ratio_out}, 24'h000100);
    host.rd(8'h0e, got);
    cmp(got, 24'h000000);
    host.rd(8'h14, got);
    cmp(got, 24'h000000);
    $display("reset test done");
    // every field code, with unused bits written as ones
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      v = {k[1:0], k, k[1:0], k[0], k[1:0], k[1:0], 1'b1, k[0], k[0], 1'b1};
      host.wr(8'h0c, {8'hff, v});
      host.rd(8'h0c, got);
      cmp(got, {8'h00, v & 16'hfff6});
      exp_sets = {k, k[1:0], k[0], k[1:0], k[1:0], k[0], k[0], ~k[0]};
      cmp({11'h0, sets}, {11'h0, exp_sets});
      cmp({11'h0, oversample_ratio_out}, {11'h0, 13'h0020 << k});
      pulses = 0;
      repeat (16) begin
        @(negedge mclk_in);
        if (analog_clock_out === 1'b1) pulses++;
      end
      cmp(24'(pulses), 24'h000010 >> k[1:0]);
    end
    $display("setup test done");
    host.wr(8'h0e, 24'h000010);
    host.wr(8'h14, 24'hfffff0);
    host.rd(8'h0e, got);
    cmp(got, 24'h000010);
    host.rd(8'h14, got);
    cmp(got, 24'hfffff0);
    host.rd(8'h20, got);
    cmp(got, 24'h000000);
    sample(24'h000064, 24'h000005, 24'h000064, 24'h000005);
    offset_trim_enable_in = 1'b1;
    sample(24'h000064, 24'h000005, 24'h000074, 24'hfffff5);
    sample(24'hfffff8, 24'h000005, 24'h000008, 24'hfffff5);
    // full-scale codes clamp instead of wrapping
    sample(24'h7ffff8, 24'h800002, 24'h7fffff, 24'h800000);
    offset_trim_enable_in = 1'b0;
    host.rd(8'h0e, got);
    cmp(got, 24'h000010);
    $display("trim test done");
    // mid-run reset must restore every default and clear both trims
    @(negedge mclk_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    rst_n_in = 1'b1;
    host.rd(8'h0c, got);
    cmp(got, 24'h001e02);
    cmp({11'h0, sets}, 24'h000f02);
    host.rd(8'h14, got);
    cmp(got, 24'h000000);
    offset_trim_enable_in = 1'b1;
    sample(24'h000064, 24'h000005, 24'h000064, 24'h000005);
    $display("reset rerun test done");
    summarize();
  end
endmodule : dual_adc_setup_trim_test

bind dual_adc_setup_trim dual_adc_checker chk (.*);

`default_nettype wire

// file: testbench/host_model.sv
// host side: register writes and reads over the strobe port
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic        mclk_in,
  input  wire logic        rvalid_in,
  input  wire logic [23:0] rdata_in,
  output var  logic        wr_out,
  output var  logic        rd_out,
  output var  logic [7:0]  addr_out,
  output var  logic [23:0] wdata_out
);
  // idle bus at time zero
  initial begin
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    addr_out  = 8'h00;
    wdata_out = 24'h000000;
  end
  // one-cycle strobe; stale data inverted so it never looks current
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(negedge mclk_in);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge mclk_in);
    wr_out    = 1'b0;
    wdata_out = ~d;
  endtask : wr
  // bounded wait for the registered answer
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(negedge mclk_in);
    addr_out = a;
    rd_out   = 1'b1;
    @(negedge mclk_in);
    rd_out   = 1'b0;
    repeat (3) if (rvalid_in !== 1'b1) @(negedge mclk_in);
    d = (rvalid_in === 1'b1) ? rdata_in : 24'hxxxxxx;
  endtask : rd
endmodule : host_model

`default_nettype wire
